// >>> tcoc_ctrl.sv
// timer compare-output control: AXI4-Lite registers, prescalers,
// waveform logic and pin control.
// assumes counter and compare logic on ref_clk send one-cycle pulses.
//
// Decided for this implementation: the AXI4-Lite slave port.

`timescale 1ns/1ps

module tcoc_ctrl
   import tcoc_pkg::*;
#(
   parameter int unsigned PRESC_W = TCOC_PRESC_W
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [TCOC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [TCOC_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [TCOC_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [TCOC_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input tcoc_evt_t timer_evt,
   input wire logic async_clk_mode,
   output tcoc_ctrl_t timer_ctrl,
   output logic timer_tick,
   output logic deadtime_tick,
   output tcoc_pins_t pins
);

   // ==========================================================
   // elaboration check
   if (PRESC_W < TCOC_PRESC_W || PRESC_W > TCOC_TAP_W)
   begin : g_bad_presc
      $error("prescaler width out of range");
   end

   // ==========================================================
   // state
   typedef struct packed {
      tcoc_ctrl_t ctrl;
      logic [PRESC_W-1:0] presc;
      logic [TCOC_DT_W-1:0] dt;
      logic [TCOC_NUM_CH-1:0] wf;
      tcoc_pins_t pins;
      logic t_tick;
      logic d_tick;
      logic aw_held;
      logic [TCOC_ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [TCOC_DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [TCOC_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } tcoc_state_t;

   localparam tcoc_state_t STATE_RST = '{ctrl: TCOC_CTRL_RST, default: '0};

   tcoc_state_t s_r;
   tcoc_state_t s_nxt;

   // ==========================================================
   // functions
   // byte address of a register index
   function automatic logic [TCOC_ADDR_W-1:0] byte_addr(
      input logic [7:0] idx
   );
      return TCOC_ADDR_W'({idx, 2'b00});
   endfunction

   // divider tap: low n count bits all ones
   function automatic logic tap_hit(
      input logic [TCOC_TAP_W-1:0] cnt,
      input logic [3:0] n,
      input logic src
   );
      logic [TCOC_TAP_W-1:0] mask;
      mask = '0;
      for (int i = 0; i < TCOC_TAP_W; i++)
         mask[i] = (i < int'(n));
      return src && ((cnt & mask) == mask);
   endfunction

   // next waveform level of one channel
   function automatic logic wf_step(
      input logic cur,
      input logic [1:0] com,
      input logic pwm,
      input logic dual,
      input logic match,
      input logic zero,
      input logic down,
      input logic force_cmp
   );
      logic r;
      r = cur;
      if (com == TCOC_COM_OFF)
         r = cur;
      else if (!pwm)
      begin
         if (match || force_cmp)
         begin
            case (com)
               TCOC_COM_TOGGLE: r = ~cur;
               TCOC_COM_CLEAR: r = 1'b0;
               default: r = 1'b1;
            endcase
         end
      end
      else if (!dual)
      begin
         // match after zero so a match at zero wins
         if (zero)
            r = (com != TCOC_COM_SET);
         if (match)
            r = (com == TCOC_COM_SET);
      end
      else if (match)
      begin
         r = (com == TCOC_COM_SET) ? !down : down;
      end
      return r;
   endfunction

   // register read value and decode hit
   function automatic logic [TCOC_REG_W:0] read_reg(
      input logic [TCOC_ADDR_W-1:0] addr,
      input tcoc_ctrl_t c,
      input logic [TCOC_NUM_CH-1:0] wf
   );
      logic [TCOC_REG_W-1:0] v;
      logic hit;
      v = TCOC_REG_RST;
      hit = 1'b1;
      if (addr == byte_addr(TCOC_IDX_CTRL_A))
      begin
         // force bits stay zero on read
         v[TCOC_A_MODE_A +: TCOC_MODE_W] = c.mode_a;
         v[TCOC_A_MODE_B +: TCOC_MODE_W] = c.mode_b;
         v[TCOC_A_FORCE_A] = 1'b0;
         v[TCOC_A_FORCE_B] = 1'b0;
         v[TCOC_A_MODEN_A] = c.moden[TCOC_CH_A];
         v[TCOC_A_MODEN_B] = c.moden[TCOC_CH_B];
      end
      else if (addr == byte_addr(TCOC_IDX_CTRL_B))
      begin
         v[TCOC_B_INV] = c.inv;
         v[TCOC_B_PSR] = 1'b0;
         v[TCOC_B_DT +: 2] = c.dt_div;
         v[TCOC_B_CS +: 4] = c.clk_sel;
      end
      else if (addr == byte_addr(TCOC_IDX_CTRL_C))
      begin
         v[TCOC_C_SHADOW_A +: TCOC_MODE_W] = c.mode_a;
         v[TCOC_C_SHADOW_B +: TCOC_MODE_W] = c.mode_b;
         v[TCOC_C_MODE_D +: TCOC_MODE_W] = c.mode_d;
         v[TCOC_C_FORCE_D] = 1'b0;
         v[TCOC_C_MODEN_D] = c.moden[TCOC_CH_D];
      end
      else if (addr == byte_addr(TCOC_IDX_WGEN))
         v[TCOC_W_GEN +: 2] = c.wgen;
      else if (addr == byte_addr(TCOC_IDX_STATUS))
      begin
         v[TCOC_S_WF +: TCOC_NUM_CH] = wf;
         v[TCOC_S_SIX] = c.moden[TCOC_CH_A] && c.wgen[TCOC_WGEN_SIX];
         v[TCOC_S_RUN] = (c.clk_sel != TCOC_CS_STOP);
      end
      else
         hit = 1'b0;
      return {hit, v};
   endfunction

   // ==========================================================
   // handshake outputs
   assign s_axi_awready = !s_r.aw_held && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_held && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;

   // ==========================================================
   // next state
   always_comb
   begin
      logic aw_fire;
      logic w_fire;
      logic do_write;
      logic [TCOC_ADDR_W-1:0] wr_addr;
      logic [TCOC_REG_W-1:0] wd;
      logic [3:0] wr_strb;
      logic [TCOC_NUM_CH-1:0] force_wr;
      logic psr_wr;
      logic src;
      logic six;
      logic dual;
      logic wf_src;
      logic [1:0] com;
      logic [TCOC_NUM_CH-1:0] wf_new;
      logic [TCOC_REG_W:0] rd;
      aw_fire = 1'b0;
      w_fire = 1'b0;
      do_write = 1'b0;
      wr_addr = '0;
      wd = '0;
      wr_strb = '0;
      force_wr = '0;
      psr_wr = 1'b0;
      src = 1'b0;
      six = 1'b0;
      dual = 1'b0;
      wf_src = 1'b0;
      com = TCOC_COM_OFF;
      wf_new = '0;
      rd = '0;
      s_nxt = s_r;

      // write address and data, taken in either order
      aw_fire = s_axi_awvalid && s_axi_awready;
      w_fire = s_axi_wvalid && s_axi_wready;
      wr_addr = s_r.aw_held ? s_r.aw_addr : s_axi_awaddr;
      wd = s_r.w_held ? s_r.w_data[TCOC_REG_W-1:0]
                      : s_axi_wdata[TCOC_REG_W-1:0];
      wr_strb = s_r.w_held ? s_r.w_strb : s_axi_wstrb;
      do_write = (s_r.aw_held || aw_fire) && (s_r.w_held || w_fire);
      if (aw_fire)
      begin
         s_nxt.aw_held = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_fire)
      begin
         s_nxt.w_held = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;

      // register writes, low byte lane only
      if (do_write)
      begin
         rd = read_reg(wr_addr, s_r.ctrl, s_r.wf);
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = rd[TCOC_REG_W] ? TCOC_RESP_OKAY : TCOC_RESP_SLVERR;
         if (wr_strb[0])
         begin
            if (wr_addr == byte_addr(TCOC_IDX_CTRL_A))
            begin
               s_nxt.ctrl.mode_a = wd[TCOC_A_MODE_A +: TCOC_MODE_W];
               s_nxt.ctrl.mode_b = wd[TCOC_A_MODE_B +: TCOC_MODE_W];
               s_nxt.ctrl.moden[TCOC_CH_A] = wd[TCOC_A_MODEN_A];
               s_nxt.ctrl.moden[TCOC_CH_B] = wd[TCOC_A_MODEN_B];
               force_wr[TCOC_CH_A] = wd[TCOC_A_FORCE_A];
               force_wr[TCOC_CH_B] = wd[TCOC_A_FORCE_B];
            end
            else if (wr_addr == byte_addr(TCOC_IDX_CTRL_B))
            begin
               s_nxt.ctrl.inv = wd[TCOC_B_INV];
               psr_wr = wd[TCOC_B_PSR];
               s_nxt.ctrl.dt_div = wd[TCOC_B_DT +: 2];
               s_nxt.ctrl.clk_sel = wd[TCOC_B_CS +: 4];
            end
            else if (wr_addr == byte_addr(TCOC_IDX_CTRL_C))
            begin
               s_nxt.ctrl.mode_a = wd[TCOC_C_SHADOW_A +: TCOC_MODE_W];
               s_nxt.ctrl.mode_b = wd[TCOC_C_SHADOW_B +: TCOC_MODE_W];
               s_nxt.ctrl.mode_d = wd[TCOC_C_MODE_D +: TCOC_MODE_W];
               s_nxt.ctrl.moden[TCOC_CH_D] = wd[TCOC_C_MODEN_D];
               force_wr[TCOC_CH_D] = wd[TCOC_C_FORCE_D];
            end
            else if (wr_addr == byte_addr(TCOC_IDX_WGEN))
               s_nxt.ctrl.wgen = wd[TCOC_W_GEN +: 2];
         end
      end

      // read channel, one read under way at a time
      if (s_axi_arvalid && s_axi_arready)
      begin
         rd = read_reg(s_axi_araddr, s_r.ctrl, s_r.wf);
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = {{(TCOC_DATA_W-TCOC_REG_W){1'b0}},
                        rd[TCOC_REG_W-1:0]};
         s_nxt.rresp = rd[TCOC_REG_W] ? TCOC_RESP_OKAY : TCOC_RESP_SLVERR;
      end
      else if (s_r.rvalid && s_axi_rready)
      begin
         s_nxt.rvalid = 1'b0;
      end

      // clock prescaler, source chosen by clocking mode
      src = async_clk_mode ? timer_evt.pck_tick : 1'b1;
      if (psr_wr)
         s_nxt.presc = '0;
      else if (src)
         s_nxt.presc = s_r.presc + 1'b1;
      s_nxt.t_tick = (s_r.ctrl.clk_sel != TCOC_CS_STOP) &&
                     tap_hit(TCOC_TAP_W'(s_r.presc),
                             s_r.ctrl.clk_sel - TCOC_CS_ONE, src);

      // dead-time prescaler on the undivided timer clock
      if (src)
         s_nxt.dt = s_r.dt + 1'b1;
      s_nxt.d_tick = tap_hit(TCOC_TAP_W'(s_r.dt),
                             {2'b00, s_r.ctrl.dt_div}, src);

      // waveforms use the post-write settings
      six = s_nxt.ctrl.moden[TCOC_CH_A] &&
            s_nxt.ctrl.wgen[TCOC_WGEN_SIX];
      dual = s_nxt.ctrl.wgen[TCOC_WGEN_SLOPE];
      for (int ch = 0; ch < TCOC_NUM_CH; ch++)
      begin
         com = (ch == TCOC_CH_A) ? s_nxt.ctrl.mode_a :
               (ch == TCOC_CH_B) ? s_nxt.ctrl.mode_b : s_nxt.ctrl.mode_d;
         wf_new[ch] = wf_step(s_r.wf[ch], com, s_nxt.ctrl.moden[ch], dual,
                              timer_evt.match[ch], timer_evt.at_zero,
                              timer_evt.count_down,
                              force_wr[ch] && !s_nxt.ctrl.moden[ch]);
      end
      s_nxt.wf = wf_new;

      // pin drive and connection per channel
      for (int ch = 0; ch < TCOC_NUM_CH; ch++)
      begin
         com = (ch == TCOC_CH_A) ? s_nxt.ctrl.mode_a :
               (ch == TCOC_CH_B) ? s_nxt.ctrl.mode_b : s_nxt.ctrl.mode_d;
         if (six)
         begin
            // all pins follow the channel A waveform
            wf_src = wf_new[TCOC_CH_A];
            s_nxt.pins.true_oe[ch] = (s_nxt.ctrl.mode_a != TCOC_COM_OFF);
            s_nxt.pins.comp_oe[ch] = (s_nxt.ctrl.mode_a != TCOC_COM_OFF);
         end
         else
         begin
            wf_src = wf_new[ch];
            s_nxt.pins.true_oe[ch] = (com != TCOC_COM_OFF);
            s_nxt.pins.comp_oe[ch] = s_nxt.ctrl.moden[ch] &&
                                     (com == TCOC_COM_TOGGLE);
         end
         s_nxt.pins.true_lvl[ch] = wf_src ^ s_nxt.ctrl.inv;
         s_nxt.pins.comp_lvl[ch] = ~wf_src ^ s_nxt.ctrl.inv;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         s_r <= STATE_RST;
      else
         s_r <= s_nxt;
   end

   // ==========================================================
   // outputs from flip-flops
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign timer_ctrl = s_r.ctrl;
   assign timer_tick = s_r.t_tick;
   assign deadtime_tick = s_r.d_tick;
   // oe is override only; direction bits gate the drivers
   assign pins = s_r.pins;

endmodule

// >>> tcoc_pkg.sv
// package of the timer compare-output control block: register indices,
// field positions, reset values, codes and the carrier structs.
// assumes the AXI4-Lite slave places each 8-bit register in the low byte
// of one aligned word at byte address four times its index.

package tcoc_pkg;

   // ==========================================================
   // bus geometry
   localparam int unsigned TCOC_ADDR_W = 8;
   localparam int unsigned TCOC_DATA_W = 32;
   localparam int unsigned TCOC_REG_W = 8;
   localparam logic [1:0] TCOC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TCOC_RESP_SLVERR = 2'h2;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] TCOC_IDX_CTRL_A = 8'h30;
   localparam logic [7:0] TCOC_IDX_CTRL_B = 8'h2F;
   localparam logic [7:0] TCOC_IDX_CTRL_C = 8'h27;
   localparam logic [7:0] TCOC_IDX_WGEN = 8'h26;
   localparam logic [7:0] TCOC_IDX_STATUS = 8'h28;
   localparam logic [7:0] TCOC_REG_RST = 8'h00;

   // ==========================================================
   // field positions (lsb of each field)
   localparam int unsigned TCOC_MODE_W = 2;
   localparam int unsigned TCOC_A_MODE_A = 6;
   localparam int unsigned TCOC_A_MODE_B = 4;
   localparam int unsigned TCOC_A_FORCE_A = 3;
   localparam int unsigned TCOC_A_FORCE_B = 2;
   localparam int unsigned TCOC_A_MODEN_A = 1;
   localparam int unsigned TCOC_A_MODEN_B = 0;
   localparam int unsigned TCOC_B_INV = 7;
   localparam int unsigned TCOC_B_PSR = 6;
   localparam int unsigned TCOC_B_DT = 4;
   localparam int unsigned TCOC_B_CS = 0;
   localparam int unsigned TCOC_C_SHADOW_A = 6;
   localparam int unsigned TCOC_C_SHADOW_B = 4;
   localparam int unsigned TCOC_C_MODE_D = 2;
   localparam int unsigned TCOC_C_FORCE_D = 1;
   localparam int unsigned TCOC_C_MODEN_D = 0;
   localparam int unsigned TCOC_W_GEN = 0;
   localparam int unsigned TCOC_S_WF = 0;
   localparam int unsigned TCOC_S_SIX = 3;
   localparam int unsigned TCOC_S_RUN = 4;

   // ==========================================================
   // channels, codes, prescaler
   localparam int unsigned TCOC_NUM_CH = 3;
   localparam int unsigned TCOC_CH_A = 0;
   localparam int unsigned TCOC_CH_B = 1;
   localparam int unsigned TCOC_CH_D = 2;
   localparam logic [1:0] TCOC_COM_OFF = 2'h0;
   localparam logic [1:0] TCOC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCOC_COM_CLEAR = 2'h2;
   localparam logic [1:0] TCOC_COM_SET = 2'h3;
   localparam logic [3:0] TCOC_CS_STOP = 4'h0;
   localparam logic [3:0] TCOC_CS_ONE = 4'h1;
   localparam int unsigned TCOC_WGEN_SLOPE = 0;
   localparam int unsigned TCOC_WGEN_SIX = 1;
   localparam int unsigned TCOC_PRESC_W = 14;
   localparam int unsigned TCOC_DT_W = 3;
   localparam int unsigned TCOC_TAP_W = 16;

   // ==========================================================
   // carrier structs
   typedef struct packed {
      logic [2:0] match;     // compare match per channel a,b,d
      logic at_zero;         // counter equals zero
      logic count_down;      // counter is counting down
      logic pck_tick;        // fast peripheral source pulse
   } tcoc_evt_t;

   typedef struct packed {
      logic [2:0] true_lvl;
      logic [2:0] comp_lvl;
      logic [2:0] true_oe;
      logic [2:0] comp_oe;
   } tcoc_pins_t;

   typedef struct packed {
      logic [1:0] mode_a;
      logic [1:0] mode_b;
      logic [1:0] mode_d;
      logic [2:0] moden;     // modulator enables d,b,a
      logic inv;
      logic [1:0] dt_div;
      logic [3:0] clk_sel;
      logic [1:0] wgen;
   } tcoc_ctrl_t;

   localparam tcoc_ctrl_t TCOC_CTRL_RST = tcoc_ctrl_t'(0);

endpackage

// >>> tcoc_ctrl_monitor.sv
// assertion checker on the timer compare-output control ports.
// assumes one ref_clk domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tcoc_ctrl_monitor
   import tcoc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [TCOC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [TCOC_DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input tcoc_evt_t timer_evt,
   input wire logic async_clk_mode,
   input tcoc_ctrl_t timer_ctrl,
   input wire logic timer_tick,
   input tcoc_pins_t pins
);
   // ==========================================================
   // helper logic
   logic [TCOC_ADDR_W-1:0] rd_addr_r;
   logic six;
   // six-output mode decode
   assign six = timer_ctrl.moden[0] && timer_ctrl.wgen[1];
   // address of the read under way
   always_ff @(posedge ref_clk)
   begin
      if (s_axi_arvalid && s_axi_arready)
         rd_addr_r <= s_axi_araddr;
   end
   // ==========================================================
   // properties
   default clocking mon_cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence fast_b_on;
      $stable(timer_ctrl) && timer_ctrl.moden[1] && timer_ctrl.wgen == 2'h0
         && timer_ctrl.mode_b != TCOC_COM_OFF;
   endsequence
   write_resp_a: assert property (wr_taken |=> s_axi_bvalid
      && !s_axi_awready && !s_axi_wready) else $error("no write resp");
   read_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready
      && s_axi_rdata[31:8] == 24'h000000) else $error("read data bad");
   force_zero_a: assert property (
      s_axi_rvalid && rd_addr_r == 8'hC0 |-> s_axi_rdata[3:2] == 2'h0)
      else $error("force bits read back");
   presc_zero_a: assert property (
      s_axi_rvalid && rd_addr_r == 8'hBC |-> !s_axi_rdata[6])
      else $error("psr bit read back");
   comp_pin_a: assert property (
      $stable(timer_ctrl) && !six && pins.comp_oe[1] |-> timer_ctrl.moden[1]
      && timer_ctrl.mode_b == TCOC_COM_TOGGLE) else $error("comp pin on");
   override_pin_a: assert property (
      $stable(timer_ctrl) && !six |-> pins.true_oe[0] ==
      (timer_ctrl.mode_a != TCOC_COM_OFF)) else $error("override wrong");
   comp_level_a: assert property (
      !$past(reset) |-> pins.comp_lvl == ~pins.true_lvl)
      else $error("comp not inverse");
   six_share_a: assert property (
      $stable(timer_ctrl) && six |-> pins.true_lvl == {3{pins.true_lvl[0]}}
      && pins.true_oe == {3{timer_ctrl.mode_a != TCOC_COM_OFF}})
      else $error("six pins differ");
   toggle_match_a: assert property (
      $stable(timer_ctrl) && !timer_ctrl.moden[0] && timer_evt.match[0]
      && timer_ctrl.mode_a == TCOC_COM_TOGGLE
      |=> pins.true_lvl[0] != $past(pins.true_lvl[0]))
      else $error("toggle missing");
   fast_match_a: assert property (
      fast_b_on ##0 timer_evt.match[1] |=> pins.true_lvl[1] ==
      ((timer_ctrl.mode_b == TCOC_COM_SET) ^ timer_ctrl.inv))
      else $error("fast match wrong");
   fast_zero_a: assert property (
      fast_b_on ##0 timer_evt.at_zero && !timer_evt.match[1]
      |=> pins.true_lvl[1] ==
      ((timer_ctrl.mode_b != TCOC_COM_SET) ^ timer_ctrl.inv))
      else $error("fast zero wrong");
   tick_every_a: assert property (
      timer_ctrl.clk_sel == TCOC_CS_ONE && !async_clk_mode
      && $stable(timer_ctrl.clk_sel) |=> timer_tick) else $error("no tick");
   tick_stop_a: assert property (
      timer_ctrl.clk_sel == TCOC_CS_STOP
      && $past(timer_ctrl.clk_sel) == TCOC_CS_STOP |=> !timer_tick)
      else $error("tick while stopped");
endmodule
bind tcoc_ctrl tcoc_ctrl_monitor u_tcoc_ctrl_monitor (.ref_clk(ref_clk),
   .reset(reset), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .timer_evt(timer_evt),
   .async_clk_mode(async_clk_mode), .timer_ctrl(timer_ctrl),
   .timer_tick(timer_tick), .pins(pins));

// >>> tb.sv
// self-checking bench for the timer compare-output control block.
// assumes the bench plays both the bus master and the timer events.
`timescale 1ns/1ps
module tb
   import tcoc_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [2:0] ev_match = 3'h0;
   logic ev_zero = 1'b0, ev_down = 1'b0, fast_peripheral_source = 1'b0;
   logic async_mode = 1'b0, pck_run = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ttick, dtick;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   tcoc_ctrl_t ctrl;
   tcoc_pins_t pins;
   logic [7:0] regs [4] = '{8'hC0, 8'hBC, 8'h9C, 8'h98};
   logic [2:0] wf = 3'h0;
   logic [1:0] code;
   int mismatches = 0;
   int check_count = 0;
   int tt, dt;
   // clock; source pulse every other cycle
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) fast_peripheral_source <= pck_run & ~fast_peripheral_source;
   tcoc_ctrl u_tcoc_ctrl (.ref_clk(ref_clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_evt({ev_match, ev_zero, ev_down, fast_peripheral_source}),
      .async_clk_mode(async_mode), .timer_ctrl(ctrl), .timer_tick(ttick),
      .deadtime_tick(dtick), .pins(pins));
   // ==========================================================
   // compare, bus and event tasks
   task automatic chk(input logic [31:0] got, exp,
      input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic aw_t, w_t, aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d))
      begin
         @(negedge ref_clk);
         aw_t = awready;
         w_t = wready;
         @(posedge ref_clk);
         aw_d |= aw_t;
         w_d |= w_t;
         awvalid <= !aw_d;
         wvalid <= !w_d;
      end
      do @(negedge ref_clk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er}, "write resp");
      @(posedge ref_clk);
      bready <= 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge ref_clk); while (arready !== 1'b1);
      @(posedge ref_clk);
      arvalid <= 1'b0;
      do @(negedge ref_clk); while (rvalid !== 1'b1);
      chk(rdata, exp, "read data");
      chk({30'h0, rresp}, {30'h0, er}, "read resp");
      @(posedge ref_clk);
      rready <= 1'b0;
   endtask
   // one-cycle timer event, then settle
   task automatic ev(input logic [2:0] m, input logic z, input logic d);
      @(posedge ref_clk);
      ev_match <= m;
      ev_zero <= z;
      ev_down <= d;
      @(posedge ref_clk);
      ev_match <= 3'h0;
      ev_zero <= 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic pin_chk(input int ch, input logic l, input logic t,
      input logic c);
      chk({31'h0, pins.true_lvl[ch]}, {31'h0, l}, "true level");
      chk({31'h0, pins.comp_lvl[ch]}, {31'h0, ~l}, "comp level");
      chk({31'h0, pins.true_oe[ch]}, {31'h0, t}, "true enable");
      chk({31'h0, pins.comp_oe[ch]}, {31'h0, c}, "comp enable");
   endtask
   // counts prescaler pulses
   task automatic ticks(input int cyc);
      tt = 0;
      dt = 0;
      repeat (8) @(negedge ref_clk);
      repeat (cyc)
      begin
         @(negedge ref_clk);
         tt += ttick;
         dt += dtick;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      give_verdict;
   end
   // ==========================================================
   // test sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (regs[i]) axi_read(regs[i], 32'h0, TCOC_RESP_OKAY);
      axi_read(8'h04, 32'h0, TCOC_RESP_SLVERR);
      axi_write(8'h04, 32'hFF, TCOC_RESP_SLVERR);
      axi_write(8'hC0, 32'hCE, TCOC_RESP_OKAY);
      axi_read(8'hC0, 32'hC2, TCOC_RESP_OKAY);
      chk({29'h0, ctrl.moden}, 32'h1, "enable a");
      axi_read(8'h9C, 32'hC0, TCOC_RESP_OKAY);
      axi_write(8'h9C, 32'h6E, TCOC_RESP_OKAY);
      axi_read(8'hC0, 32'h62, TCOC_RESP_OKAY);
      chk({30'h0, ctrl.mode_d}, 32'h3, "mode d");
      axi_write(8'hBC, 32'hFF, TCOC_RESP_OKAY);
      axi_read(8'hBC, 32'hBF, TCOC_RESP_OKAY);
      foreach (regs[i]) axi_write(regs[i], 32'h0, TCOC_RESP_OKAY);
      $display("test registers done");
      for (int k = 0; k < 4; k++)
      begin
         code = k[1:0] + 2'h1;
         axi_write(8'hC0, {24'h0, code, 6'h00}, TCOC_RESP_OKAY);
         ev(3'h1, 1'b0, 1'b0);
         wf[0] = code == 2'h1 ? ~wf[0] : code == 2'h0 ? wf[0] : code[0];
         pin_chk(0, wf[0], code != 2'h0, 1'b0);
      end
      axi_write(8'hC0, 32'h48, TCOC_RESP_OKAY);
      pin_chk(0, 1'b0, 1'b1, 1'b0);
      axi_write(8'hC0, 32'hCA, TCOC_RESP_OKAY);
      pin_chk(0, 1'b0, 1'b1, 1'b0);
      $display("test normal mode done");
      for (int k = 1; k < 4; k++)
      begin
         code = k[1:0];
         axi_write(8'hC0, {26'h0, code, 4'h1}, TCOC_RESP_OKAY);
         ev(3'h0, 1'b1, 1'b0);
         pin_chk(1, code != 2'h3, 1'b1, code == 2'h1);
         ev(3'h2, 1'b1, 1'b0);
         pin_chk(1, code == 2'h3, 1'b1, code == 2'h1);
      end
      axi_write(8'h98, 32'h1, TCOC_RESP_OKAY);
      for (int k = 1; k < 4; k++)
      begin
         code = k[1:0];
         axi_write(8'h9C, {28'h0, code, 2'h1}, TCOC_RESP_OKAY);
         ev(3'h4, 1'b0, 1'b1);
         pin_chk(2, code != 2'h3, 1'b1, code == 2'h1);
         ev(3'h4, 1'b0, 1'b0);
         pin_chk(2, code == 2'h3, 1'b1, code == 2'h1);
      end
      $display("test modulating modes done");
      axi_write(8'h9C, 32'h0, TCOC_RESP_OKAY);
      axi_write(8'h98, 32'h2, TCOC_RESP_OKAY);
      axi_write(8'hC0, 32'h42, TCOC_RESP_OKAY);
      ev(3'h0, 1'b1, 1'b0);
      for (int c = 0; c < 3; c++) pin_chk(c, 1'b1, 1'b1, 1'b1);
      axi_write(8'hBC, 32'h80, TCOC_RESP_OKAY);
      for (int c = 0; c < 3; c++) pin_chk(c, 1'b0, 1'b1, 1'b1);
      ev(3'h1, 1'b0, 1'b0);
      for (int c = 0; c < 3; c++) pin_chk(c, 1'b1, 1'b1, 1'b1);
      axi_read(8'hA0, 32'hE, TCOC_RESP_OKAY);
      $display("test six-output done");
      for (int k = 0; k < 4; k++)
      begin
         axi_write(8'hBC, {26'h0, k[1:0], k[3:0] + 4'h1}, TCOC_RESP_OKAY);
         ticks(64);
         chk(tt, 64 >> k, "timer ticks");
         chk(dt, 64 >> k, "dt ticks");
      end
      axi_write(8'hBC, 32'h0, TCOC_RESP_OKAY);
      ticks(64);
      chk(tt, 0, "stopped ticks");
      @(posedge ref_clk);
      async_mode <= 1'b1;
      pck_run <= 1'b1;
      axi_write(8'hBC, 32'h42, TCOC_RESP_OKAY);
      axi_read(8'hBC, 32'h02, TCOC_RESP_OKAY);
      ticks(64);
      chk(tt, 16, "async ticks");
      chk(dt, 32, "async dt ticks");
      $display("test prescalers done");
      give_verdict;
   end
endmodule
